// ### include/msnf_pkg.sv
// Constants, types and register map of the shift/normalize block
package msnf_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_OPND0 = 8'h00;
  localparam logic [7:0] OFS_OPND1 = 8'h04;
  localparam logic [7:0] OFS_OPND2 = 8'h08;
  localparam logic [7:0] OFS_OPND3 = 8'h0c;
  localparam logic [7:0] OFS_OPND4 = 8'h10;
  localparam logic [7:0] OFS_OPND5 = 8'h14;
  localparam logic [7:0] OFS_CTL   = 8'h18;

  // Internal register selects
  localparam logic [2:0] SEL_B0   = 3'h0;
  localparam logic [2:0] SEL_B1   = 3'h1;
  localparam logic [2:0] SEL_B2   = 3'h2;
  localparam logic [2:0] SEL_B3   = 3'h3;
  localparam logic [2:0] SEL_B4   = 3'h4;
  localparam logic [2:0] SEL_B5   = 3'h5;
  localparam logic [2:0] SEL_CTL  = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // Control register field positions
  localparam int unsigned CNT_MSB = 4;
  localparam int unsigned DIR_BIT = 5;
  localparam int unsigned OVF_BIT = 6;
  localparam int unsigned ERR_BIT = 7;

  // Reset values
  localparam logic [7:0] OPND_RST = 8'h00;
  localparam logic [4:0] CNT_RST  = 5'h00;

  // Shifter pacing in shifts per machine cycle (one aclk each), normalize shift limit, and write counts that select the multiply or divide kind
  localparam logic [2:0] STEP_FIRST = 3'h4;
  localparam logic [2:0] STEP_NEXT  = 3'h6;
  localparam logic [4:0] NORM_MAX   = 5'h1f;
  localparam logic [2:0] SEQ_DIV32  = 3'h4;
  localparam logic [2:0] SEQ_SHORT  = 3'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation kind selected by the write order
  typedef enum logic [2:0] {
    OP_NONE, OP_SHIFT, OP_MUL, OP_DIV16, OP_DIV32
  } msnf_op_e;

  // Result of a multiply or divide
  typedef struct packed {
    logic [31:0] lo;
    logic [15:0] rem;
    logic        ovf;
  } msnf_md_res_s;

endpackage : msnf_pkg

// ### src/msnf_muldiv.sv
// Single-cycle multiply and divide on the operand bytes
module msnf_muldiv
  import msnf_pkg::*;
(
  input  wire logic [31:0]  a32,
  input  wire logic [15:0]  d16,
  input  msnf_op_e          kind,
  output msnf_md_res_s      r
);

  logic [31:0] prod;

  // Divide by zero yields an all-ones quotient and keeps the dividend's low 16 bits as remainder
  always_comb begin
    r    = '0;
    prod = a32[15:0] * d16;
    case (kind)
      OP_MUL: begin
        r.lo  = prod;
        r.ovf = |prod[31:16];
      end
      OP_DIV16: begin
        if (d16 == 16'h0000) begin
          r.lo  = {a32[31:16], 16'hffff};
          r.rem = a32[15:0];
          r.ovf = 1'b1;
        end else begin
          r.lo  = {a32[31:16], a32[15:0] / d16};
          r.rem = a32[15:0] % d16;
        end
      end
      OP_DIV32: begin
        if (d16 == 16'h0000) begin
          r.lo  = 32'hffffffff;
          r.rem = a32[15:0];
          r.ovf = 1'b1;
        end else begin
          r.lo  = a32 / {16'h0000, d16};
          r.rem = 16'(a32 % {16'h0000, d16});
        end
      end
      default: r = '0;
    endcase
  end

endmodule : msnf_muldiv

// ### src/msnf_shift_step.sv
// One machine cycle of the operand shifter
module msnf_shift_step
  import msnf_pkg::*;
(
  input  wire logic [31:0] val,
  input  wire logic        right,
  input  wire logic        norm,
  input  wire logic [2:0]  amt,
  output logic      [31:0] res,
  output logic      [2:0]  done
);

  // Up to six single-bit shifts; normalize stops once the MSB is set
  always_comb begin
    res  = val;
    done = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < amt && (!norm || !res[31])) begin
        res  = right ? (res >> 1) : (res << 1); // zero fill
        done = done + 3'h1;
      end
    end
  end

endmodule : msnf_shift_step

// ### src/msnf_top.sv
// Shift/normalize path, operand bytes, flags and AXI4-Lite slave

// Contract
// - Control write with nonzero count starts shift
// - Zero count in control write means normalize
// - Shifts fill zeros at vacated operand end
// - Four shifts first cycle, six afterwards
// - Shift or normalize ends within six cycles
// - Byte 0-3 read or byte 0 write while busy sets error flag
// - Overflow on div zero, big product, normalize with MSB already set
// - Operations without overflow condition clear it
// - Software cannot write the overflow flag
// - Byte 0 write arms sequence monitoring
// - Final result read disarms monitoring
// - Byte 0 rewrite while armed sets error
// - Error flag read-only, cleared by read
// - Illegal reads never corrupt the result
// - Normalize shifts left until MSB set
// - Count field returns normalize shift count
// - Byte 0 write resets unit, starts monitoring
// - Byte 5 write starts selected mul/div
module msnf_top
  import msnf_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  // Operand bytes 0..5 and control state
  logic [7:0]        opnd [6];
  logic              aw_done;
  logic              w_done;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte;
  logic              wstrb0;
  logic              dir;
  logic [4:0]        count;
  logic              ovf;
  logic              err;
  logic              armed;
  msnf_op_e          op;
  logic [2:0]        seq_cnt;
  logic              seq_b4_first;
  logic              busy;
  logic              first;
  logic              norm;
  logic [4:0]        remain;

  // Combinational decode and datapath values
  logic              do_wr;
  logic [2:0]        wsel;
  logic [2:0]        rsel;
  logic              wr_hit;
  logic              rd_hit;
  logic              w_b0;
  logic              w_b5;
  logic              w_ctl;
  logic              w_mid;
  logic              rd_final;
  logic              err_set;
  logic              err_clr;
  msnf_op_e          seq_op;
  logic              md_start;
  msnf_md_res_s      md_res;
  logic [2:0]        base;
  logic [2:0]        amt;
  logic [31:0]       step_res;
  logic [2:0]        step_done;
  logic [4:0]        remain_n;
  logic              fin;
  logic [31:0]       rd_word;

  // Address to register select; anything else is unmapped
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == OFS_OPND0) begin
      reg_sel = SEL_B0;
    end else if (a == OFS_OPND1) begin
      reg_sel = SEL_B1;
    end else if (a == OFS_OPND2) begin
      reg_sel = SEL_B2;
    end else if (a == OFS_OPND3) begin
      reg_sel = SEL_B3;
    end else if (a == OFS_OPND4) begin
      reg_sel = SEL_B4;
    end else if (a == OFS_OPND5) begin
      reg_sel = SEL_B5;
    end else if (a == OFS_CTL) begin
      reg_sel = SEL_CTL;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction : reg_sel

  // Register access events; only byte lane 0 carries data
  assign do_wr  = aw_done & w_done & ~bvalid;
  assign wsel   = reg_sel(awaddr_q);
  assign rsel   = reg_sel(araddr);
  assign wr_hit = do_wr & wstrb0;
  assign rd_hit = arvalid & arready;
  assign w_b0   = wr_hit && (wsel == SEL_B0);
  assign w_b5   = wr_hit && (wsel == SEL_B5);
  assign w_ctl  = wr_hit && (wsel == SEL_CTL);
  assign w_mid  = wr_hit && (wsel >= SEL_B1) && (wsel <= SEL_B4);

  // Operation kind implied by the writes since byte 0
  always_comb begin
    seq_op = OP_NONE;
    if (seq_cnt == SEQ_DIV32) begin
      seq_op = OP_DIV32;
    end else if (seq_cnt == SEQ_SHORT) begin
      seq_op = seq_b4_first ? OP_MUL : OP_DIV16;
    end
  end

  // A stray byte 5 write that matches no order starts nothing
  assign md_start = w_b5 && armed && (op == OP_NONE) &&
                    (seq_op != OP_NONE);

  msnf_muldiv u_muldiv (
    .a32  ({opnd[3], opnd[2], opnd[1], opnd[0]}),
    .d16  ({wbyte, opnd[4]}),
    .kind (seq_op),
    .r    (md_res)
  );

  // Shift amount this cycle, never past the programmed count
  assign base = first ? STEP_FIRST : STEP_NEXT;
  assign amt  = (remain < {2'h0, base}) ? remain[2:0] : base;

  msnf_shift_step u_step (
    .val   ({opnd[3], opnd[2], opnd[1], opnd[0]}),
    .right (dir & ~norm),
    .norm  (norm),
    .amt   (amt),
    .res   (step_res),
    .done  (step_done)
  );

  // Normalize also ends once the MSB is one
  assign remain_n = remain - {2'h0, step_done};
  assign fin = norm ? ((remain_n == 5'h00) || step_res[31] ||
                       (step_done < amt))
                    : (remain_n == 5'h00);

  // Shift engine: 31 shifts take 4+6*4+3, so six cycles at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy   <= 1'b0;
      first  <= 1'b0;
      norm   <= 1'b0;
      remain <= CNT_RST;
    end else if (w_b0) begin
      busy <= 1'b0;
    end else if (w_ctl) begin
      busy   <= 1'b1;
      first  <= 1'b1;
      norm   <= (wbyte[CNT_MSB:0] == 5'h00);
      remain <= (wbyte[CNT_MSB:0] == 5'h00) ? NORM_MAX
                                           : wbyte[CNT_MSB:0];
    end else if (busy) begin
      first  <= 1'b0;
      remain <= remain_n;
      if (fin) begin
        busy <= 1'b0;
      end
    end
  end

  // Operand bytes; reads never touch them, so results survive
  // out-of-order or early reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 6; i++) begin
        opnd[i] <= OPND_RST;
      end
    end else begin
      if (wr_hit && (wsel <= SEL_B5)) begin
        opnd[wsel] <= wbyte;
      end
      if (busy && !w_b0) begin
        opnd[0] <= step_res[7:0];
        opnd[1] <= step_res[15:8];
        opnd[2] <= step_res[23:16];
        opnd[3] <= step_res[31:24];
      end
      if (md_start) begin
        opnd[0] <= md_res.lo[7:0];
        opnd[1] <= md_res.lo[15:8];
        opnd[2] <= md_res.lo[23:16];
        opnd[3] <= md_res.lo[31:24];
        if (seq_op != OP_MUL) begin
          opnd[4] <= md_res.rem[7:0];
          opnd[5] <= md_res.rem[15:8];
        end
      end
    end
  end

  // Direction and count; count reports normalize shifts at the end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir   <= 1'b0;
      count <= CNT_RST;
    end else if (w_ctl) begin
      dir   <= wbyte[DIR_BIT];
      count <= wbyte[CNT_MSB:0];
    end else if (busy && norm && fin && !w_b0) begin
      count <= NORM_MAX - remain_n;
    end
  end

  // Overflow is decided at each start; bus writes never reach it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf <= 1'b0;
    end else if (w_ctl) begin
      ovf <= (wbyte[CNT_MSB:0] == 5'h00) && opnd[3][7];
    end else if (md_start) begin
      ovf <= md_res.ovf;
    end
  end

  // Error events; a set in the clearing cycle wins
  assign err_set = (w_b0 && armed) ||
                   (busy && ((rd_hit && (rsel <= SEL_B3)) ||
                             w_b0));
  assign err_clr = rd_hit && (rsel == SEL_CTL);
  assign rd_final = rd_hit &&
                    (((rsel == SEL_B3) &&
                      ((op == OP_SHIFT) || (op == OP_MUL))) ||
                     ((rsel == SEL_B5) &&
                      ((op == OP_DIV16) || (op == OP_DIV32))));

  // Error flag, cleared by reading the control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err <= 1'b0;
    end else begin
      err <= err_set | (err & ~err_clr);
    end
  end

  // Monitor arming and operation kind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b0;
      op    <= OP_NONE;
    end else if (w_b0) begin
      armed <= 1'b1;
      op    <= OP_NONE;
    end else if (w_ctl) begin
      op <= OP_SHIFT;
    end else if (md_start) begin
      op <= seq_op;
    end else if (rd_final) begin
      armed <= 1'b0;
      op    <= OP_NONE;
    end
  end

  // Write order tracking between byte 0 and byte 5
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_cnt      <= 3'h0;
      seq_b4_first <= 1'b0;
    end else if (w_b0) begin
      seq_cnt      <= 3'h0;
      seq_b4_first <= 1'b0;
    end else if (w_mid) begin
      if (seq_cnt != 3'h7) begin
        seq_cnt <= seq_cnt + 3'h1; // Saturates, never wraps
      end
      if (wsel == SEL_B4 && seq_cnt == 3'h0) begin
        seq_b4_first <= 1'b1;
      end
    end
  end

  // Read data; unused upper bits read as zero
  always_comb begin
    rd_word = 32'h00000000;
    if (rsel <= SEL_B5) begin
      rd_word = {24'h000000, opnd[rsel]};
    end else if (rsel == SEL_CTL) begin
      rd_word = {24'h000000, err, ovf, dir, count};
    end
  end

  // Write channels: address and data taken in either order,
  // response one cycle after both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      aw_done  <= 1'b0;
      w_done   <= 1'b0;
      awaddr_q <= '0;
      wbyte    <= 8'h00;
      wstrb0   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_done  <= 1'b1;
        awaddr_q <= awaddr;
        awready  <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done <= 1'b1;
        wbyte  <= wdata[7:0];
        wstrb0 <= wstrb[0];
        wready <= 1'b0;
      end
      if (do_wr) begin
        bvalid  <= 1'b1;
        bresp   <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        aw_done <= 1'b0;
        w_done  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read channel: data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      if (rd_hit) begin
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        arready <= 1'b0;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : msnf_top

// ### tb/msnf_checker.sv
// Bus timing assertions on the shift/normalize block ports
module msnf_checker
  import msnf_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Handshakes; the master offers both write channels at one edge
  logic wr_hs;
  logic rd_hs;
  assign wr_hs = awvalid && awready && wvalid && wready;
  assign rd_hs = arvalid && arready;

  property p_b_lat;
    wr_hs |=> !bvalid ##1 bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write answer off its slot");

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped early");

  property p_w_refuse;
    wr_hs |=> !awready && !wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse)
    else $error("second write taken while busy");

  property p_w_back;
    bvalid && bready |=> awready && wready;
  endproperty
  a_w_back: assert property (p_w_back)
    else $error("write channel not reopened");

  property p_r_lat;
    rd_hs |=> rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");

  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped early");

  property p_r_refuse;
    rvalid |-> !arready && rdata[31:8] == 24'h0;
  endproperty
  a_r_refuse: assert property (p_r_refuse)
    else $error("read channel open or wide data");

  property p_unmapped;
    rd_hs && araddr > OFS_CTL |=> rresp == RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");

  c_slow_b: cover property (bvalid && !bready ##1 bready);
  c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
  c_err: cover property (rd_hs && araddr == OFS_CTL ##1 rdata[ERR_BIT]);
endmodule : msnf_checker

bind msnf_top msnf_checker chk (.*);

// ### tb/msnf_cpu_model.sv
// Bus master standing in for the CPU core on the register bus
module msnf_cpu_model
  import msnf_pkg::*;
(
  input  wire logic              aclk,
  output logic      [ADDR_W-1:0] awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic      [31:0]       wdata,
  output logic      [3:0]        wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic      [ADDR_W-1:0] araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  timeunit 1ns;
  timeprecision 1ns;

  // Cycles before an answer is accepted; nonzero models a slow core
  int lag = 0;

  // Idle levels from time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
  end

  // One write: both channels offered, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int k = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (lag == 0);
    do begin
      @(posedge aclk);
      k++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (k >= lag)
        bready <= 1'b1;
    end while (!(bready && bvalid));
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  // One read; data taken at the edge that completes it
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int k = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= (lag == 0);
    do begin
      @(posedge aclk);
      k++;
      if (arready)
        arvalid <= 1'b0;
      if (k >= lag)
        rready <= 1'b1;
    end while (!(rready && rvalid));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd
endmodule : msnf_cpu_model

// ### tb/tb.sv
// Self-checking bench for the shift/normalize block
module tb
  import msnf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // Operand and control word of each shift/normalize case
  logic [31:0] tv [8] = '{32'h80000001, 32'h12345678, 32'h80000000,
    32'hffffffff, 32'hdeadbeef, 32'h00012345, 32'h0, 32'h40000000};
  logic [7:0]  tc [8] = '{8'h00, 8'h04, 8'h3f, 8'h1f, 8'h2a, 8'h00,
    8'h00, 8'hc0};

  msnf_top dut (.*);
  msnf_cpu_model cpu (.*);

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Cuts a hang short; the run needs far fewer cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] v);
    cpu.wr(a, {24'h0, v}, r);
  endtask : w

  task automatic rb(input logic [7:0] a);
    cpu.rd(a, d, r);
  endtask : rb

  // Operand loaded low byte first, as the core does
  task automatic ld(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      w(8'(4 * i), v[8 * i +: 8]);
  endtask : ld

  task automatic rd4(output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      rb(8'(4 * i));
      v[8 * i +: 8] = d[7:0];
    end
  endtask : rd4

  // Multiply is picked by writing byte 4 right after byte 0
  task automatic mul(input logic [15:0] a, input logic [15:0] b);
    w(OFS_OPND0, a[7:0]);
    w(OFS_OPND4, b[7:0]);
    w(OFS_OPND1, a[15:8]);
    w(OFS_OPND5, b[15:8]);
  endtask : mul

  // Normalize shift count; an all-zero operand gives the maximum
  function automatic logic [4:0] lz(input logic [31:0] v);
    lz = 5'h1f;
    for (int i = 0; i < 32; i++)
      if (v[i])
        lz = 5'(31 - i);
  endfunction : lz

  initial begin
    logic [31:0] v, ev, m;
    logic [4:0]  n;
    logic        nrm;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state, read by a slow core
    cpu.lag = 2;
    rb(OFS_CTL);
    chk(d, 32'h0);
    rb(OFS_OPND3);
    chk(d, 32'h0);
    cpu.lag = 0;
    // Shifts both ways and normalizes, read after six cycles
    for (int k = 0; k < 8; k++) begin
      ld(tv[k]);
      w(OFS_CTL, tc[k]);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      repeat (6) @(posedge aclk);
      rd4(v);
      nrm = (tc[k][4:0] == 5'h00);
      n = nrm ? lz(tv[k]) : tc[k][4:0];
      ev = (nrm || !tc[k][5]) ? tv[k] << n : tv[k] >> n;
      chk(v, ev);
      rb(OFS_CTL);
      m = nrm ? 32'hdf : 32'hc0;
      chk(d & m, {25'h0, nrm & tv[k][31], 1'b0, n} & m);
    end
    // Pacing: ten shifts end in two cycles, eleven need a third,
    // so only the second early read is flagged
    ld(32'h00000001);
    w(OFS_CTL, 8'h0a);
    rd4(v);
    chk(v, 32'h00000400);
    rb(OFS_CTL);
    chk(d & 32'h80, 32'h0);
    ld(32'h00000001);
    w(OFS_CTL, 8'h0b);
    rd4(v);
    chk(v, 32'h00000800);
    rb(OFS_CTL);
    chk(d & 32'h80, 32'h80);
    // Early read during a long shift flags it but keeps the result
    ld(32'hffffffff);
    w(OFS_CTL, 8'h1f);
    rb(OFS_OPND0);
    repeat (6) @(posedge aclk);
    rd4(v);
    chk(v, 32'h80000000);
    rb(OFS_CTL);
    chk(d & 32'h80, 32'h80);
    rb(OFS_CTL);
    chk(d & 32'h80, 32'h0);
    // Clean multiply, then an overflowing one restarted mid read-out
    mul(16'h0003, 16'h0004);
    rd4(v);
    chk(v, 32'h0000000c);
    mul(16'h0100, 16'h0100);
    rb(OFS_CTL);
    chk(d & 32'hc0, 32'h40);
    rb(OFS_OPND2);
    chk(d, 32'h01);
    w(OFS_OPND0, 8'h00);
    rb(OFS_CTL);
    chk(d & 32'h80, 32'h80);
    // Division by zero
    w(OFS_OPND0, 8'h34);
    w(OFS_OPND1, 8'h12);
    w(OFS_OPND4, 8'h00);
    w(OFS_OPND5, 8'h00);
    rb(OFS_CTL);
    chk(d & 32'h40, 32'h40);
    // Long divide over an unread one: restart flagged, overflow cleared
    w(OFS_OPND0, 8'h64);
    w(OFS_OPND1, 8'h00);
    w(OFS_OPND2, 8'h00);
    w(OFS_OPND3, 8'h00);
    w(OFS_OPND4, 8'h07);
    w(OFS_OPND5, 8'h00);
    rb(OFS_CTL);
    chk(d & 32'hc0, 32'h80);
    rd4(v);
    chk(v, 32'h0000000e);
    rb(OFS_OPND4);
    chk(d, 32'h02);
    rb(OFS_OPND5);
    chk(d, 32'h00);
    w(OFS_OPND0, 8'h00);
    rb(OFS_CTL);
    chk(d & 32'h80, 32'h0);
    // Unmapped place, slow core
    cpu.lag = 3;
    rb(8'h40);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    cpu.wr(8'h40, 32'h5a, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    close_out();
  end
endmodule : tb
